/* File: design/sfrpc_ctrl.v */
// Output-frequency setpoint generator with starting frequency, start hold
// and three ramp patterns. Frequencies are in 0.01 Hz, times in 0.1 s.
// Assumes start and direction arrive on pins from another domain.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sfrpc_regs.vh"

module sfrpc_ctrl #(
   parameter TICK_CYCLES = `SFRPC_TICK_CYCLES
) (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire pslverr,
   output reg [31:0] prdata,
   // Run pins
   input wire start_pin,
   input wire reverse_pin,
   // Setpoint to the modulation stage
   output reg [15:0] freq_setpoint,
   output reg reverse_out,
   output wire running
);

   // ***************************************************************
   // States
   // ***************************************************************
   localparam [2:0] ST_STOP = 3'h1;
   localparam [2:0] ST_HOLD = 3'h2;
   localparam [2:0] ST_RUN = 3'h4;
   localparam [31:0] TICK_LAST32 = TICK_CYCLES - 1;
   localparam [31:0] TENTH_TICKS32 = `SFRPC_TICKS_PER_TENTH;
   localparam [22:0] TICKS_PER_TENTH = TENTH_TICKS32[22:0];

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   reg start_s1_q;
   reg start_s2_q;
   reg rev_s1_q;
   reg rev_s2_q;

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         start_s1_q <= 1'b0;
         start_s2_q <= 1'b0;
         rev_s1_q <= 1'b0;
         rev_s2_q <= 1'b0;
      end
      else
      begin
         start_s1_q <= start_pin;
         start_s2_q <= start_s1_q;
         rev_s1_q <= reverse_pin;
         rev_s2_q <= rev_s1_q;
      end
   end

   // ***************************************************************
   // Registers and APB slave
   // ***************************************************************
   reg [1:0] pattern_q;
   reg [15:0] start_freq_q;
   reg [15:0] hold_q;
   reg [15:0] min_freq_q;
   reg [15:0] base_freq_q;
   reg [15:0] ref_freq_q;
   reg [15:0] accel_q;
   reg [15:0] decel_q;
   reg [15:0] cmd_q;
   reg [2:0] state_q;
   reg [15:0] freq_q;
   reg dir_q;
   wire run_ok;
   reg mapped;
   reg [31:0] rd_mux;

   wire wr_en = psel & penable & pwrite;
   wire [15:0] wd = pwdata[15:0];

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   always @*
   begin
      mapped = 1'b1;
      rd_mux = 32'h00000000;
      case (paddr)
         `SFRPC_CTRL_OFS: rd_mux = {30'h00000000, pattern_q};
         `SFRPC_START_FREQ_OFS: rd_mux = {16'h0000, start_freq_q};
         `SFRPC_HOLD_OFS: rd_mux = {16'h0000, hold_q};
         `SFRPC_MIN_FREQ_OFS: rd_mux = {16'h0000, min_freq_q};
         `SFRPC_BASE_FREQ_OFS: rd_mux = {16'h0000, base_freq_q};
         `SFRPC_REF_FREQ_OFS: rd_mux = {16'h0000, ref_freq_q};
         `SFRPC_ACCEL_OFS: rd_mux = {16'h0000, accel_q};
         `SFRPC_DECEL_OFS: rd_mux = {16'h0000, decel_q};
         `SFRPC_CMD_OFS: rd_mux = {16'h0000, cmd_q};
         `SFRPC_STATUS_OFS: rd_mux = {27'h0000000, run_ok, dir_q, state_q};
         `SFRPC_OUT_FREQ_OFS: rd_mux = {16'h0000, freq_q};
         default: mapped = 1'b0;
      endcase
   end

   // Read data is captured in the setup cycle so it is a flop in the access cycle.
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         prdata <= 32'h00000000;
      else if (psel & ~penable)
         prdata <= rd_mux;
   end

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pattern_q <= `SFRPC_PAT_LINEAR; // [RULE9]
         start_freq_q <= `SFRPC_START_RST;
         hold_q <= `SFRPC_HOLD_RST;
         min_freq_q <= `SFRPC_MIN_RST;
         base_freq_q <= `SFRPC_BASE_RST;
         ref_freq_q <= `SFRPC_REF_RST; // [RULE14]
         accel_q <= `SFRPC_ACCEL_RST;
         decel_q <= `SFRPC_DECEL_RST;
         cmd_q <= `SFRPC_CMD_RST;
      end
      else if (wr_en)
      begin
         case (paddr)
            `SFRPC_CTRL_OFS:
            begin
               // Code 3 is not a pattern, so such a write leaves the old one.
               if (pwdata[`SFRPC_PAT_MSB:`SFRPC_PAT_LSB] != 2'h3)
                  pattern_q <= pwdata[`SFRPC_PAT_MSB:`SFRPC_PAT_LSB]; // [RULE9]
            end
            `SFRPC_START_FREQ_OFS:
               start_freq_q <= (wd > `SFRPC_START_MAX) ? `SFRPC_START_MAX : wd; // [RULE1]
            `SFRPC_HOLD_OFS:
               hold_q <= (wd > `SFRPC_HOLD_MAX && wd != `SFRPC_HOLD_OFF) ?
                         `SFRPC_HOLD_MAX : wd; // [RULE4]
            `SFRPC_MIN_FREQ_OFS: min_freq_q <= wd;
            `SFRPC_BASE_FREQ_OFS: base_freq_q <= wd;
            `SFRPC_REF_FREQ_OFS: ref_freq_q <= wd;
            `SFRPC_ACCEL_OFS: accel_q <= wd;
            `SFRPC_DECEL_OFS: decel_q <= wd;
            `SFRPC_CMD_OFS: cmd_q <= wd;
            default: ;
         endcase
      end
   end

   // ***************************************************************
   // Control tick
   // ***************************************************************
   reg [16:0] tick_cnt_q;
   wire tick = (tick_cnt_q == TICK_LAST32[16:0]);

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         tick_cnt_q <= 17'h00000;
      else if (tick)
         tick_cnt_q <= 17'h00000;
      else
         tick_cnt_q <= tick_cnt_q + 17'h00001;
   end

   // ***************************************************************
   // Command qualification and target
   // ***************************************************************
   wire preset_mode = (start_freq_q <= min_freq_q);
   wire [15:0] eff_cmd = (preset_mode && cmd_q < min_freq_q) ? min_freq_q : cmd_q; // [RULE8]
   assign run_ok = start_s2_q && (eff_cmd >= start_freq_q); // [RULE2]
   wire dir_change = (rev_s2_q != dir_q);
   wire [15:0] target = (run_ok && !dir_change) ? eff_cmd : 16'h0000; // [RULE7]
   wire [15:0] hold_freq = (start_freq_q == 16'h0000) ?
                           `SFRPC_ZERO_HOLD_FREQ : start_freq_q; // [RULE5]
   wire hold_en = (hold_q != `SFRPC_HOLD_OFF) && (hold_q != 16'h0000); // [RULE4]

   // ***************************************************************
   // Ramp rate: credit C per tick, one 0.01 Hz step per threshold D
   // ***************************************************************
   // The step loop moves at most one unit per clock, so a ramp steeper than
   // TICK_CYCLES units per tick is limited; real settings stay far below it.
   reg [15:0] seg_start_q;
   reg [15:0] target_q;
   reg [39:0] acc_q;
   reg [39:0] credit;
   reg [39:0] thresh;
   reg [15:0] from_d;
   reg [15:0] to_d;
   reg [15:0] near_d;
   reg [16:0] span;
   wire accel = (target > freq_q);
   wire [15:0] time_set = accel ? accel_q : decel_q;
   wire [22:0] t_ticks = (time_set == 16'h0000) ? 23'h000001 :
                         ({7'h00, time_set} * TICKS_PER_TENTH); // [RULE15]

   always @*
   begin
      from_d = (freq_q > seg_start_q) ? freq_q - seg_start_q : seg_start_q - freq_q;
      to_d = accel ? target - freq_q : freq_q - target;
      near_d = (from_d < to_d) ? from_d : to_d;
      span = {1'b0, from_d} + {1'b0, to_d};
      credit = {24'h000000, ref_freq_q}; // [RULE10]
      thresh = {17'h00000, t_ticks}; // [RULE14]
      case (pattern_q)
         `SFRPC_PAT_S_A:
         begin
            if (freq_q < base_freq_q)
            begin
               // Rate rises toward the base point, giving the concave half.
               credit = {23'h000000, {1'b0, base_freq_q} + {1'b0, freq_q}}; // [RULE11]
               thresh = {16'h0000, t_ticks, 1'b0}; // [RULE12]
            end
            else
            begin
               // Constant-power region: rate falls as base^2 / f.
               credit = {24'h0, base_freq_q} * {24'h0, base_freq_q}; // [RULE11]
               thresh = {17'h0, t_ticks} * {24'h0, freq_q}; // [RULE12]
            end
         end
         `SFRPC_PAT_S_B:
         begin
            credit = {24'h0, ref_freq_q} * {23'h0, {1'b0, near_d} + 17'h00001}; // [RULE13]
            thresh = {17'h0, t_ticks} * {23'h0, {1'b0, span[16:1]} + 17'h00001}; // [RULE13]
         end
         default: ;
      endcase
   end

   // ***************************************************************
   // Start, hold and run sequencer
   // ***************************************************************
   reg [13:0] hold_cnt_q;
   wire [22:0] hold_ticks = {7'h00, hold_q} * TICKS_PER_TENTH;
   wire step_due = (acc_q >= thresh);
   wire at_floor = (target == 16'h0000) && (freq_q <= hold_freq);

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= ST_STOP;
         freq_q <= 16'h0000;
         dir_q <= 1'b0;
         hold_cnt_q <= 14'h0000;
         acc_q <= 40'h0000000000;
         seg_start_q <= 16'h0000;
         target_q <= 16'h0000;
      end
      else
      begin
         target_q <= target;
         case (state_q)
            ST_STOP:
            begin
               freq_q <= 16'h0000;
               acc_q <= 40'h0000000000;
               if (run_ok) // [RULE2]
               begin
                  dir_q <= rev_s2_q;
                  seg_start_q <= start_freq_q;
                  if (hold_en)
                  begin
                     freq_q <= hold_freq; // [RULE5]
                     hold_cnt_q <= hold_ticks[13:0]; // [RULE16]
                     state_q <= ST_HOLD; // [RULE3]
                  end
                  else
                  begin
                     freq_q <= start_freq_q; // [RULE1]
                     state_q <= ST_RUN;
                  end
               end
            end
            ST_HOLD:
            begin
               if (!start_s2_q)
                  state_q <= ST_RUN; // [RULE6]
               else if (hold_cnt_q == 14'h0000)
                  state_q <= ST_RUN; // [RULE16]
               else if (tick)
                  hold_cnt_q <= hold_cnt_q - 14'h0001; // [RULE3]
            end
            ST_RUN:
            begin
               if (at_floor && run_ok && dir_change)
               begin
                  // Reversal restarts from the starting frequency with no hold.
                  freq_q <= start_freq_q; // [RULE7]
                  dir_q <= rev_s2_q;
                  seg_start_q <= start_freq_q;
                  acc_q <= 40'h0000000000;
               end
               else if (at_floor)
               begin
                  freq_q <= 16'h0000;
                  state_q <= ST_STOP;
               end
               else if (freq_q == target)
                  acc_q <= 40'h0000000000;
               else
               begin
                  if (target != target_q)
                     seg_start_q <= freq_q; // [RULE13]
                  if (step_due)
                  begin
                     acc_q <= acc_q - thresh + (tick ? credit : 40'h0000000000); // [RULE15]
                     freq_q <= accel ? freq_q + 16'h0001 : freq_q - 16'h0001; // [RULE10]
                  end
                  else if (tick)
                     acc_q <= acc_q + credit; // [RULE15]
               end
            end
            default:
               state_q <= ST_STOP;
         endcase
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         freq_setpoint <= 16'h0000;
         reverse_out <= 1'b0;
      end
      else
      begin
         freq_setpoint <= freq_q;
         reverse_out <= dir_q;
      end
   end

   assign running = (state_q != ST_STOP);

endmodule // sfrpc_ctrl
`default_nettype wire

/* File: design/sfrpc_regs.vh */
// Constants for the starting-frequency and ramp-pattern controller.
// Assumes a 125 MHz system clock and an APB master that reaches the registers.
//
// How it works
// RULE1: Starting frequency 0..60 Hz is first output.
// RULE2: Stay stopped while command below starting frequency.
// RULE3: Hold starting frequency for hold duration first.
// RULE4: Hold 0.0..10.0 s; value 9999 disables hold.
// RULE5: Zero starting frequency holds at 0.01 Hz.
// RULE6: Start removed during hold: decelerate at once.
// RULE7: Direction reversal keeps starting frequency, skips hold.
// RULE8: Start alone runs preset when start below minimum.
// RULE9: Linear 0, S-A 1, S-B 2; reset 0.
// RULE10: Linear mode changes frequency at constant rate.
// RULE11: S-curve A inflects at base frequency.
// RULE12: S-curve A ramp time counts to base frequency.
// RULE13: S-curve B shapes every change current to target.
// RULE14: Linear time runs zero to reference; reference 50 Hz.
// RULE15: Ramp advances per tick from reference over ticks.
// RULE16: Hold counter starts at hold duration in ticks, then releases.
`ifndef SFRPC_REGS_VH
`define SFRPC_REGS_VH

// ***************************************************************
// Timing
// ***************************************************************
`define SFRPC_CLK_NS 8
`define SFRPC_TICK_NS 1000000
`define SFRPC_TENTH_NS 100000000
`define SFRPC_TICK_CYCLES (`SFRPC_TICK_NS / `SFRPC_CLK_NS)
`define SFRPC_TICKS_PER_TENTH (`SFRPC_TENTH_NS / `SFRPC_TICK_NS)

// ***************************************************************
// Register offsets
// ***************************************************************
`define SFRPC_CTRL_OFS 8'h00
`define SFRPC_START_FREQ_OFS 8'h04
`define SFRPC_HOLD_OFS 8'h08
`define SFRPC_MIN_FREQ_OFS 8'h0C
`define SFRPC_BASE_FREQ_OFS 8'h10
`define SFRPC_REF_FREQ_OFS 8'h14
`define SFRPC_ACCEL_OFS 8'h18
`define SFRPC_DECEL_OFS 8'h1C
`define SFRPC_CMD_OFS 8'h20
`define SFRPC_STATUS_OFS 8'h24
`define SFRPC_OUT_FREQ_OFS 8'h28

// ***************************************************************
// Fields, limits and reset values
// ***************************************************************
`define SFRPC_PAT_LSB 0
`define SFRPC_PAT_MSB 1
`define SFRPC_PAT_LINEAR 2'h0
`define SFRPC_PAT_S_A 2'h1
`define SFRPC_PAT_S_B 2'h2
`define SFRPC_START_MAX 16'h1770
`define SFRPC_HOLD_MAX 16'h0064
`define SFRPC_HOLD_OFF 16'h270F
`define SFRPC_ZERO_HOLD_FREQ 16'h0001
`define SFRPC_START_RST 16'h0032
`define SFRPC_HOLD_RST 16'h270F
`define SFRPC_MIN_RST 16'h0000
`define SFRPC_BASE_RST 16'h1388
`define SFRPC_REF_RST 16'h1388
`define SFRPC_ACCEL_RST 16'h0032
`define SFRPC_DECEL_RST 16'h0032
`define SFRPC_CMD_RST 16'h0000

`endif

/* File: dv/sfrpc_motor_model.sv */
// Modulation-stage stand-in that takes the setpoint and direction.
// Assumes one clock shared with the block; it never pushes back.
`timescale 1ns/1ps
`default_nettype none
module sfrpc_motor_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Setpoint from the block
   input wire logic [15:0] freq_setpoint,
   input wire logic reverse_out,
   input wire logic running,
   // Bench view
   input wire logic clear,
   output logic [15:0] peak_q
);
   // ***********************************
   // Peak frequency seen since clear
   // ***********************************
   // The stage only follows the setpoint, so the peak tells how far a start got.
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n || clear)
         peak_q <= 16'h0000;
      else if (running && freq_setpoint > peak_q)
         peak_q <= freq_setpoint;
   end
endmodule // sfrpc_motor_model
`default_nettype wire

/* File: dv/sfrpc_ctrl_assertions.sv */
// Port checker for the setpoint generator, bound into sfrpc_ctrl.
// Assumes a 2-flop pin sync and a setpoint one cycle behind the state.
`timescale 1ns/1ps
`default_nettype none
module sfrpc_ctrl_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Watched ports
   input wire logic start_pin,
   input wire logic reverse_pin,
   input wire logic [15:0] freq_setpoint,
   input wire logic reverse_out,
   input wire logic running
);
   // ***********************************
   // Properties
   // ***********************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   property p_idle_zero;
      !running && !$past(running) |-> freq_setpoint == 16'h0000;
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("setpoint moved while stopped");
   property p_rise_pin;
      $rose(running) |-> $past(start_pin, 3);
   endproperty
   a_rise_pin: assert property (p_rise_pin) else $error("run without start pin");
   property p_no_pin;
      !start_pin [*4] |-> ##1 !$rose(running);
   endproperty
   a_no_pin: assert property (p_no_pin) else $error("run after long pin low");
   property p_rise_max;
      $rose(running) |=> freq_setpoint <= 16'h1770;
   endproperty
   a_rise_max: assert property (p_rise_max) else $error("first frequency above limit");
   property p_step;
      running && $past(running, 2) && $stable(reverse_out) && reverse_out == $past(reverse_out, 2)
      |-> (freq_setpoint > $past(freq_setpoint) ? freq_setpoint - $past(freq_setpoint)
         : $past(freq_setpoint) - freq_setpoint) <= 16'h0001;
   endproperty
   a_step: assert property (p_step) else $error("setpoint jumped");
   property p_stop;
      $fell(running) |-> freq_setpoint <= 16'h1770 ##1 freq_setpoint == 16'h0000;
   endproperty
   a_stop: assert property (p_stop) else $error("stop from high frequency");
   property p_rev_pin;
      $changed(reverse_out) |-> reverse_out == $past(reverse_pin, 4);
   endproperty
   a_rev_pin: assert property (p_rev_pin) else $error("direction not from pin");
   property p_rev_low;
      $changed(reverse_out) |-> $past(freq_setpoint) <= 16'h1770;
   endproperty
   a_rev_low: assert property (p_rev_low) else $error("reversal at high frequency");
   c_start: cover property ($rose(running));
   c_stop: cover property ($fell(running));
   c_rev: cover property (running && $changed(reverse_out));
endmodule // sfrpc_ctrl_chk
bind sfrpc_ctrl sfrpc_ctrl_chk i_chk (.clk(clk), .reset_n(reset_n), .start_pin(start_pin),
   .reverse_pin(reverse_pin), .freq_setpoint(freq_setpoint), .reverse_out(reverse_out),
   .running(running));
`default_nettype wire

/* File: dv/test_start_freq_ramp_pattern_ctrl.sv */
// Self-checking bench for the setpoint generator over APB and run pins.
// Assumes a short tick so that holds and ramps finish in a few thousand cycles.
`timescale 1ns/1ps
`default_nettype none
module test_start_freq_ramp_pattern_ctrl;
   // ***********************************
   // Signals and instances
   // ***********************************
   localparam int TK = 20;
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, start_pin = 1'h0, reverse_pin = 1'h0;
   logic clear = 1'h0, pready, pslverr, reverse_out, running, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] freq_setpoint, peak_q;
   int mismatches = 0, checks_done = 0;
   sfrpc_ctrl #(.TICK_CYCLES(TK)) i_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .start_pin(start_pin), .reverse_pin(reverse_pin),
      .freq_setpoint(freq_setpoint), .reverse_out(reverse_out), .running(running));
   sfrpc_motor_model i_motor (.clk(clk), .reset_n(reset_n), .freq_setpoint(freq_setpoint),
      .reverse_out(reverse_out), .running(running), .clear(clear), .peak_q(peak_q));
   // ***********************************
   // Shared tasks
   // ***********************************
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do
         @(posedge clk);
      while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'h1, d);
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      apb(a, 1'h0, 32'h0);
      chk(n, e, rd);
   endtask
   task automatic cfg(input logic [31:0] s, input logic [31:0] h, input logic [31:0] c);
      wr(8'h04, s);
      wr(8'h08, h);
      wr(8'h20, c);
   endtask
   task automatic pin(input logic v);
      @(posedge clk);
      start_pin <= v;
   endtask
   task automatic wait_run(input logic v, input int n);
      for (int i = 0; i < n && running !== v; i++)
         @(posedge clk);
      chk("running", 32'(v), 32'(running));
   endtask
   task automatic wait_sp(input logic [15:0] t, input int n);
      for (int i = 0; i < n && freq_setpoint !== t; i++)
         @(posedge clk);
      chk("setpoint", 32'(t), 32'(freq_setpoint));
   endtask
   // ***********************************
   // Scenarios
   // ***********************************
   task automatic t_regs;
      rdc("ctrl", 8'h00, 32'h0);
      rdc("start", 8'h04, 32'h32);
      rdc("hold", 8'h08, 32'h270F);
      rdc("ref", 8'h14, 32'h1388);
      for (int p = 0; p < 4; p++)
      begin
         wr(8'h00, 32'(p));
         rdc("pattern", 8'h00, p < 3 ? 32'(p) : 32'h2);
      end
      wr(8'h04, 32'h1B58);
      rdc("start clamp", 8'h04, 32'h1770);
      wr(8'h08, 32'hC8);
      rdc("hold clamp", 8'h08, 32'h64);
      apb(8'h2C, 1'h0, 32'h0);
      chk("unmapped", 32'h1, 32'(err));
      wr(8'h14, 32'h64);
      wr(8'h18, 32'h1);
      wr(8'h1C, 32'h1);
      wr(8'h00, 32'h0);
      $display("regs done");
   endtask
   task automatic t_below;
      cfg(32'h1F4, 32'h0, 32'h190);
      pin(1'h1);
      repeat (100) @(posedge clk);
      chk("stays stopped", 32'h0, 32'(running));
      wr(8'h20, 32'h1F4);
      wait_run(1'h1, 20);
      pin(1'h0);
      wait_run(1'h0, 5000);
      $display("below done");
   endtask
   task automatic t_hold;
      logic [15:0] a;
      cfg(32'hC8, 32'h1, 32'h190);
      pin(1'h1);
      wait_run(1'h1, 10);
      repeat (3) @(posedge clk);
      chk("first freq", 32'hC8, 32'(freq_setpoint));
      repeat (1900) @(posedge clk);
      chk("held", 32'hC8, 32'(freq_setpoint));
      repeat (300) @(posedge clk);
      chk("released", 32'h1, 32'(freq_setpoint > 16'hC8));
      a = freq_setpoint;
      repeat (400) @(posedge clk);
      chk("linear rate", 32'(a + 16'h14), 32'(freq_setpoint));
      pin(1'h0);
      wait_run(1'h0, 6000);
      $display("hold done");
   endtask
   task automatic t_zero_abort;
      cfg(32'h0, 32'h1, 32'h190);
      pin(1'h1);
      wait_run(1'h1, 10);
      repeat (3) @(posedge clk);
      chk("zero start", 32'h1, 32'(freq_setpoint));
      pin(1'h0);
      wait_run(1'h0, 50);
      clear <= 1'h1;
      cfg(32'h12C, 32'h1, 32'h190);
      clear <= 1'h0;
      pin(1'h1);
      repeat (500) @(posedge clk);
      pin(1'h0);
      wait_run(1'h0, 30);
      chk("abort peak", 32'h12C, 32'(peak_q));
      $display("zero abort done");
   endtask
   task automatic t_preset;
      cfg(32'h64, 32'h0, 32'h0);
      wr(8'h0C, 32'hC8);
      pin(1'h1);
      wait_run(1'h1, 10);
      wait_sp(16'hC8, 2500);
      pin(1'h0);
      wait_run(1'h0, 4000);
      wr(8'h0C, 32'h0);
      $display("preset done");
   endtask
   task automatic t_reverse;
      cfg(32'hC8, 32'h0, 32'h12C);
      pin(1'h1);
      wait_sp(16'h12C, 2500);
      wr(8'h08, 32'h1);
      reverse_pin <= 1'h1;
      for (int i = 0; i < 5000 && reverse_out !== 1'h1; i++)
         @(posedge clk);
      chk("reversed", 32'h1, 32'(reverse_out));
      repeat (300) @(posedge clk);
      chk("no hold", 32'h1, 32'(freq_setpoint > 16'hC8));
      pin(1'h0);
      reverse_pin <= 1'h0;
      wait_run(1'h0, 6000);
      $display("reverse done");
   endtask
   task automatic t_curves;
      wr(8'h10, 32'hFA);
      for (int p = 1; p < 3; p++)
      begin
         wr(8'h00, 32'(p));
         cfg(32'hC8, 32'h0, 32'h12C);
         pin(1'h1);
         repeat (220) @(posedge clk);
         if (p == 1)
            chk("shape A", 32'h1, 32'(freq_setpoint > 16'hD2));
         else
            chk("shape B", 32'h1, 32'(freq_setpoint < 16'hD2));
         wait_sp(16'h12C, 40000);
         pin(1'h0);
         wait_run(1'h0, 40000);
      end
      $display("curves done");
   endtask
   // ***********************************
   // Run control
   // ***********************************
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      forever #4 clk = ~clk;
   end
   initial
   begin
      repeat (80000) @(posedge clk);
      mismatches++;
      test_done;
   end
   initial
   begin
      repeat (10) @(posedge clk);
      reset_n <= 1'h1;
      t_regs;
      t_below;
      t_hold;
      t_zero_abort;
      t_preset;
      t_reverse;
      t_curves;
      test_done;
   end
endmodule // test_start_freq_ramp_pattern_ctrl
`default_nettype wire
